// [input_terminal_function_mapper_bench.sv]
// self-checking bench for the input terminal function mapper
`timescale 1ns/1ps
`default_nettype none
module input_terminal_function_mapper_bench;
    import itfm_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  pressed;
    logic [7:0]  nc_wired;
    logic [7:0]  term;
    logic [63:0] act;
    logic [5:0]  opsel;
    logic [15:0] gen;
    logic        alm;
    logic        absclr;
    logic        preset;
    logic [31:0] rd;
    logic [5:0]  rst_code [8] = '{6'h03, 6'h04, 6'h30, 6'h31,
                                  6'h32, 6'h10, 6'h12, 6'h18};
    int          n_errors;
    int          n_tests;
    int          cycles;

    itfm_switch_model itfm_switch_model_i (
        .pressed  (pressed),
        .nc_wired (nc_wired),
        .term     (term)
    );

    itfm_input_mapper itfm_input_mapper_i (
        .hclk                     (hclk),
        .hresetn                  (hresetn),
        .hsel                     (hsel),
        .haddr                    (haddr),
        .htrans                   (htrans),
        .hwrite                   (hwrite),
        .hsize                    (3'h2),
        .hready                   (hreadyout),
        .hwdata                   (hwdata),
        .hrdata                   (hrdata),
        .hreadyout                (hreadyout),
        .hresp                    (hresp),
        .input_terminal_0         (term[0]),
        .input_terminal_1         (term[1]),
        .input_terminal_2         (term[2]),
        .input_terminal_3         (term[3]),
        .input_terminal_4         (term[4]),
        .input_terminal_5         (term[5]),
        .input_terminal_6         (term[6]),
        .input_terminal_7         (term[7]),
        .active_function          (act),
        .op_data_select           (opsel),
        .general_signal           (gen),
        .alarm_clear              (alm),
        .abs_position_error_clear (absclr),
        .position_preset          (preset)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] got, input logic [63:0] exp,
                         input string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // single word transfer, rd holds read data
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check({hreadyout, hresp}, 2'b10, "bus answer");
    endtask

    // new contacts, sampled after the output edge
    task automatic drive(input logic [7:0] p);
        @(posedge hclk);
        pressed <= p;
        @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 8'(4 * i), 32'h0);
            check(rd, {26'h0, rst_code[i]}, "reset code");
        end
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0, "reset polarity");
        check(act, 64'h0000_0000_0802_0000, "unmapped held on");
        drive(8'h7f);
        check(act, 64'h0007_0000_0807_0018, "reset map");
        check(opsel, 6'h07, "reset op select");
        drive(8'h00);
        $display("test reset done");
    endtask

    task automatic t_polarity();
        nc_wired <= 8'h01;
        bus(1'b1, 8'h20, 32'h1);
        drive(8'h00);
        check(act[3], 1'b0, "inverted idle");
        drive(8'h01);
        check(act[3], 1'b1, "inverted pressed");
        bus(1'b0, 8'h38, 32'h0);
        check(rd[0], 1'b1, "corrected level");
        nc_wired <= 8'h00;
        bus(1'b1, 8'h20, 32'h0);
        drive(8'h00);
        $display("test polarity done");
    endtask

    task automatic t_dup();
        bus(1'b1, 8'h00, 32'h20);
        bus(1'b1, 8'h04, 32'h20);
        drive(8'h02);
        check(gen, 16'h0001, "or via second");
        drive(8'h01);
        check(gen, 16'h0001, "or via first");
        drive(8'h14);
        check(opsel, 6'h05, "op data bits");
        check(gen, 16'h0000, "general idle");
        bus(1'b1, 8'h28, 32'h1);
        drive(8'h00);
        check(gen, 16'h0001, "general from remote");
        bus(1'b1, 8'h28, 32'h0);
        $display("test dup done");
    endtask

    task automatic t_edges();
        bus(1'b1, 8'h18, 32'h19);
        bus(1'b1, 8'h14, 32'h1a);
        drive(8'h80);
        check(alm, 1'b0, "alarm clear on rise");
        drive(8'h00);
        check(alm, 1'b1, "alarm clear on fall");
        @(negedge hclk);
        check(alm, 1'b0, "alarm clear one cycle");
        drive(8'h40);
        check(preset, 1'b1, "preset on rise");
        @(negedge hclk);
        check(preset, 1'b0, "preset one cycle");
        drive(8'h20);
        check({preset, absclr}, 2'b00, "no pulse");
        drive(8'h00);
        check(absclr, 1'b1, "abs clear on fall");
        $display("test edges done");
    endtask

    task automatic t_and();
        bus(1'b1, 8'h00, 32'h11);
        bus(1'b1, 8'h2c, 32'h1);
        bus(1'b1, 8'h24, 32'h0);
        drive(8'h01);
        check(act[17], 1'b0, "remote off");
        bus(1'b1, 8'h24, 32'h0002_0000);
        drive(8'h01);
        check(act[17], 1'b1, "both on");
        drive(8'h00);
        check(act[17], 1'b0, "terminal off");
        bus(1'b1, 8'h04, 32'h1b);
        bus(1'b1, 8'h2c, 32'h3);
        bus(1'b1, 8'h24, 32'h0);
        drive(8'h02);
        check(act[27], 1'b0, "panel remote off");
        bus(1'b1, 8'h24, 32'h0800_0000);
        drive(8'h02);
        check(act[27], 1'b1, "panel both on");
        bus(1'b1, 8'h2c, 32'h0);
        bus(1'b1, 8'h04, 32'h04);
        $display("test and done");
    endtask

    task automatic t_illegal();
        bus(1'b1, 8'h00, 32'h0e);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0e, "stored code");
        drive(8'h01);
        check(act, 64'h0000_0000_0802_0000, "illegal none");
        bus(1'b0, 8'h3c, 32'h0);
        check(rd, 32'h0, "unmapped read");
        $display("test illegal done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_errors = 0;
        n_tests  = 0;
        cycles   = 0;
        hresetn  = 1'b0;
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'b00;
        hwrite   = 1'b0;
        hwdata   = 32'h0;
        pressed  = 8'h00;
        nc_wired = 8'h00;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_polarity();
        t_dup();
        t_edges();
        t_and();
        t_illegal();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [itfm_input_mapper.sv]
// input terminal function mapper with ahb-lite register slave
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module itfm_input_mapper
    import itfm_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // physical terminals
    input  wire logic        input_terminal_0,
    input  wire logic        input_terminal_1,
    input  wire logic        input_terminal_2,
    input  wire logic        input_terminal_3,
    input  wire logic        input_terminal_4,
    input  wire logic        input_terminal_5,
    input  wire logic        input_terminal_6,
    input  wire logic        input_terminal_7,
    // internal functions
    output logic [63:0]      active_function,
    output logic [5:0]       op_data_select,
    output logic [15:0]      general_signal,
    output logic             alarm_clear,
    output logic             abs_position_error_clear,
    output logic             position_preset
);

    ////////////////////////////////////////////////////////////////////////
    // storage

    logic [5:0]   fsel [ITFM_TERMS];
    logic [7:0]   pol;
    logic [31:0]  rmt_lo;
    logic [31:0]  rmt_hi;
    logic [1:0]   rmap;
    logic [63:0]  act;
    logic [5:0]   opsel;
    logic [15:0]  gen;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic         rd_go;
    logic [31:0]  rd_data;
    logic [7:0]   raw;
    logic [7:0]   level;
    logic [63:0]  map  [ITFM_TERMS];
    logic [63:0]  hit  [ITFM_TERMS];
    logic [63:0]  direct;
    logic [63:0]  mapped;
    logic [63:0]  remote;
    logic [63:0]  next_act;

    assign raw = {input_terminal_7, input_terminal_6, input_terminal_5,
                  input_terminal_4, input_terminal_3, input_terminal_2,
                  input_terminal_1, input_terminal_0};
    assign remote          = {rmt_hi, rmt_lo};
    assign active_function = act;
    assign op_data_select  = opsel;
    assign general_signal  = gen;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave

    // fsel word window, shared by read and write decode
    function automatic logic fsel_addr_hit(input logic [7:0] a);
        return a < ITFM_OFS_POL && a[1:0] == 2'b00;
    endfunction

    assign rd_go = hsel && htrans[1] && hready && !hwrite;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb
    begin
        rd_data = 32'h0;
        if (fsel_addr_hit(haddr[7:0]))
            rd_data = {26'h0, fsel[haddr[4:2]]};
        else
        begin
            unique case (haddr[7:0])
                ITFM_OFS_POL:    rd_data = {24'h0, pol};
                ITFM_OFS_RMT_LO: rd_data = rmt_lo;
                ITFM_OFS_RMT_HI: rd_data = rmt_hi;
                ITFM_OFS_RMAP:   rd_data = {30'h0, rmap};
                ITFM_OFS_ACT_LO: rd_data = act[31:0];
                ITFM_OFS_ACT_HI: rd_data = act[63:32];
                ITFM_OFS_TERM:   rd_data = {24'h0, level};
                default:         rd_data = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (rd_go)
            hrdata <= rd_data;
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < ITFM_TERMS; i++)
                fsel[i] <= ITFM_FSEL_RST[i];
        end
        else if (wr_pend && fsel_addr_hit(wr_addr))
            fsel[wr_addr[4:2]] <= hwdata[5:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pol <= ITFM_POL_RST;
        else if (wr_pend && wr_addr == ITFM_OFS_POL)
            pol <= hwdata[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rmt_lo <= ITFM_RMT_RST;
            rmt_hi <= ITFM_RMT_RST;
            rmap   <= ITFM_RMAP_RST;
        end
        else if (wr_pend)
        begin
            if (wr_addr == ITFM_OFS_RMT_LO)
                rmt_lo <= hwdata;
            if (wr_addr == ITFM_OFS_RMT_HI)
                rmt_hi <= hwdata;
            if (wr_addr == ITFM_OFS_RMAP)
                rmap <= hwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // terminal decode and merge

    for (genvar g = 0; g < ITFM_TERMS; g++)
    begin : g_term
        itfm_term_map itfm_term_map_i (
            .raw   (raw[g]),
            .pol   (pol[g]),
            .fsel  (fsel[g]),
            .level (level[g]),
            .map   (map[g]),
            .hit   (hit[g])
        );
    end

    always_comb
    begin
        direct = 64'h0;
        mapped = 64'h0;
        for (int i = 0; i < ITFM_TERMS; i++)
        begin
            direct = direct | hit[i];
            mapped = mapped | map[i];
        end
        next_act = direct | remote;
        unique case ({mapped[ITFM_CODE_EXC], rmap[ITFM_RMAP_EXC]})
            2'b00: next_act[ITFM_CODE_EXC] = 1'b1;
            2'b10: next_act[ITFM_CODE_EXC] = direct[ITFM_CODE_EXC];
            2'b01: next_act[ITFM_CODE_EXC] = remote[ITFM_CODE_EXC];
            2'b11: next_act[ITFM_CODE_EXC] = direct[ITFM_CODE_EXC] &
                                             remote[ITFM_CODE_EXC];
        endcase
        unique case ({mapped[ITFM_CODE_PANEL], rmap[ITFM_RMAP_PANEL]})
            2'b00: next_act[ITFM_CODE_PANEL] = 1'b1;
            2'b10: next_act[ITFM_CODE_PANEL] = direct[ITFM_CODE_PANEL];
            2'b01: next_act[ITFM_CODE_PANEL] = remote[ITFM_CODE_PANEL];
            2'b11: next_act[ITFM_CODE_PANEL] = direct[ITFM_CODE_PANEL] &
                                               remote[ITFM_CODE_PANEL];
        endcase
        next_act[ITFM_CODE_NONE] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // function levels and edge pulses

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            act   <= 64'h0;
            opsel <= 6'h00;
            gen   <= 16'h0000;
        end
        else
        begin
            act   <= next_act;
            opsel <= next_act[ITFM_CODE_OPSEL5:ITFM_CODE_OPSEL0];
            gen   <= next_act[ITFM_CODE_GEN15:ITFM_CODE_GEN0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            alarm_clear              <= 1'b0;
            abs_position_error_clear <= 1'b0;
            position_preset          <= 1'b0;
        end
        else
        begin
            alarm_clear <= act[ITFM_CODE_ALMCLR] &
                           !next_act[ITFM_CODE_ALMCLR];
            abs_position_error_clear <= act[ITFM_CODE_ABSCLR] &
                                        !next_act[ITFM_CODE_ABSCLR];
            position_preset <= !act[ITFM_CODE_PRESET] &
                               next_act[ITFM_CODE_PRESET];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_fsel_legal_only: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !itfm_code_legal(fsel[0]) |-> map[0] == 64'h0)
        else $error("terminal 0 decodes an illegal code");

    a_code_zero_idle: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !active_function[ITFM_CODE_NONE])
        else $error("code 0 reported as an active function");

    a_reset_codes: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(hreadyout) |->
        fsel[0] == ITFM_CODE_HOME && fsel[1] == ITFM_CODE_START &&
        fsel[2] == ITFM_CODE_OPSEL0 && fsel[3] == ITFM_CODE_OPSEL1 &&
        fsel[4] == ITFM_CODE_OPSEL2 && fsel[5] == ITFM_CODE_FREE &&
        fsel[6] == ITFM_CODE_STOP && fsel[7] == ITFM_CODE_ALMCLR)
        else $error("function selections wrong after reset");

    a_or_merge: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (fsel[0] == fsel[1] && fsel[0] != ITFM_CODE_EXC &&
         fsel[0] != ITFM_CODE_PANEL && (level[0] || level[1]))
        |=> act[$past(fsel[0])] || !itfm_code_legal($past(fsel[0])) ||
            $past(fsel[0]) == ITFM_CODE_NONE)
        else $error("shared function not active when one terminal is");

    a_alarm_on_fall: assert property (
        @(posedge hclk) disable iff (!hresetn)
        alarm_clear == $fell(act[ITFM_CODE_ALMCLR]))
        else $error("alarm clear not tied to falling function level");

    a_abs_on_fall: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(act[ITFM_CODE_ABSCLR]) |-> abs_position_error_clear ##1
        !abs_position_error_clear)
        else $error("abs position clear missing on falling level");

    a_preset_on_rise: assert property (
        @(posedge hclk) disable iff (!hresetn)
        position_preset |-> $rose(act[ITFM_CODE_PRESET]) &&
        !$past(position_preset))
        else $error("position preset without a rising level");

    a_exc_default: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !mapped[ITFM_CODE_EXC] && !rmap[ITFM_RMAP_EXC] &&
        !mapped[ITFM_CODE_PANEL] && !rmap[ITFM_RMAP_PANEL]
        |=> act[ITFM_CODE_EXC] && act[ITFM_CODE_PANEL])
        else $error("unassigned excitation or panel release not held on");

    a_exc_and: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mapped[ITFM_CODE_EXC] && rmap[ITFM_RMAP_EXC] |=>
        act[ITFM_CODE_EXC] == ($past(direct[ITFM_CODE_EXC]) &&
                               $past(remote[ITFM_CODE_EXC])))
        else $error("excitation not the and of terminal and remote");

    a_panel_and: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mapped[ITFM_CODE_PANEL] && rmap[ITFM_RMAP_PANEL] |=>
        act[ITFM_CODE_PANEL] == ($past(direct[ITFM_CODE_PANEL]) &&
                                 $past(remote[ITFM_CODE_PANEL])))
        else $error("panel release not the and of terminal and remote");

    a_polarity_t0: assert property (
        @(posedge hclk) disable iff (!hresetn)
        fsel[0] == ITFM_CODE_HOME && (input_terminal_0 ^ pol[0])
        |=> act[ITFM_CODE_HOME])
        else $error("polarity corrected terminal 0 did not drive its code");

    a_free_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        fsel[5] == ITFM_CODE_FREE && level[5] |=> act[ITFM_CODE_FREE])
        else $error("terminal 5 did not drive the de-excite function");

    a_opsel_bit0: assert property (
        @(posedge hclk) disable iff (!hresetn)
        fsel[2] == ITFM_CODE_OPSEL0 && level[2] |=> op_data_select[0])
        else $error("operation data select bit 0 not set");

    a_general_remote: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rmt_hi[0] |=> general_signal[0] && act[ITFM_CODE_GEN0])
        else $error("general signal 0 not driven from remote");

    a_bus_ready: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> hreadyout && !hresp)
        else $error("slave not ready or not okay");

endmodule
`default_nettype wire

// [itfm_pkg.sv]
// constants, register map and decode helpers for the input terminal mapper
// What this block does
// - per-terminal function code; legal 0-13,16-18,24-27,32-53; 0 is unused
// - reset codes: terminal 5 code 16, 6 code 18, 7 code 24
// - one function on several terminals is active if any terminal is active
// - alarm clear and abs position error clear fire on active-to-inactive
// - position preset fires on inactive-to-active
// - excitation and panel lock release held active when on neither a terminal nor the remote map
// - excitation or panel release on terminal and remote: the and of both
// - per-terminal polarity, 0 normally open, 1 inverted; reset 0
// - codes 48 to 53 form six operation data select bits, 48 the lsb
// - codes 32 to 47 are sixteen general signals without motion effect
// - reset codes: terminal 0 code 3, terminal 2 code 48
// - code 24 clears current alarm, code 26 clears abs position error
// - code 16 de-excites and releases brake, code 17 is the excitation level
// - remote inputs are a second, bus-written source of the same functions
`default_nettype none
package itfm_pkg;

    localparam int          ITFM_TERMS      = 8;
    localparam int          ITFM_CODE_W     = 6;
    localparam int          ITFM_NUM_FUNC   = 64;

    // register byte offsets
    localparam logic [7:0]  ITFM_OFS_FSEL0  = 8'h00;
    localparam logic [7:0]  ITFM_OFS_POL    = 8'h20;
    localparam logic [7:0]  ITFM_OFS_RMT_LO = 8'h24;
    localparam logic [7:0]  ITFM_OFS_RMT_HI = 8'h28;
    localparam logic [7:0]  ITFM_OFS_RMAP   = 8'h2c;
    localparam logic [7:0]  ITFM_OFS_ACT_LO = 8'h30;
    localparam logic [7:0]  ITFM_OFS_ACT_HI = 8'h34;
    localparam logic [7:0]  ITFM_OFS_TERM   = 8'h38;

    // remote map bit positions
    localparam int          ITFM_RMAP_EXC   = 0;
    localparam int          ITFM_RMAP_PANEL = 1;

    // function codes
    localparam logic [5:0]  ITFM_CODE_NONE    = 6'h00;
    localparam logic [5:0]  ITFM_CODE_HOME    = 6'h03;
    localparam logic [5:0]  ITFM_CODE_START   = 6'h04;
    localparam logic [5:0]  ITFM_CODE_FREE    = 6'h10;
    localparam logic [5:0]  ITFM_CODE_EXC     = 6'h11;
    localparam logic [5:0]  ITFM_CODE_STOP    = 6'h12;
    localparam logic [5:0]  ITFM_CODE_ALMCLR  = 6'h18;
    localparam logic [5:0]  ITFM_CODE_PRESET  = 6'h19;
    localparam logic [5:0]  ITFM_CODE_ABSCLR  = 6'h1a;
    localparam logic [5:0]  ITFM_CODE_PANEL   = 6'h1b;
    localparam logic [5:0]  ITFM_CODE_GEN0    = 6'h20;
    localparam logic [5:0]  ITFM_CODE_GEN15   = 6'h2f;
    localparam logic [5:0]  ITFM_CODE_OPSEL0  = 6'h30;
    localparam logic [5:0]  ITFM_CODE_OPSEL1  = 6'h31;
    localparam logic [5:0]  ITFM_CODE_OPSEL2  = 6'h32;
    localparam logic [5:0]  ITFM_CODE_OPSEL5  = 6'h35;

    // reset values
    localparam logic [5:0]  ITFM_FSEL_RST [ITFM_TERMS] = '{
        ITFM_CODE_HOME, ITFM_CODE_START, ITFM_CODE_OPSEL0, ITFM_CODE_OPSEL1,
        ITFM_CODE_OPSEL2, ITFM_CODE_FREE, ITFM_CODE_STOP, ITFM_CODE_ALMCLR
    };
    localparam logic [7:0]  ITFM_POL_RST    = 8'h00;
    localparam logic [31:0] ITFM_RMT_RST    = 32'h0000_0000;
    localparam logic [1:0]  ITFM_RMAP_RST   = 2'h0;

    // legal code set, code 0 included as the unused marker
    function automatic logic itfm_code_legal(input logic [5:0] c);
        return (c <= 6'h0d) ||
               (c >= ITFM_CODE_FREE   && c <= ITFM_CODE_STOP)  ||
               (c >= ITFM_CODE_ALMCLR && c <= ITFM_CODE_PANEL) ||
               (c >= ITFM_CODE_GEN0   && c <= ITFM_CODE_OPSEL5);
    endfunction

    // one-hot of the function a code drives, zero for unused or illegal
    function automatic logic [63:0] itfm_code_onehot(input logic [5:0] c);
        logic [63:0] v;
        v = 64'h0;
        if (itfm_code_legal(c) && c != ITFM_CODE_NONE)
            v[c] = 1'b1;
        return v;
    endfunction

endpackage
`default_nettype wire

// [itfm_switch_model.sv]
// switch and wiring model driving the eight input terminals
`timescale 1ns/1ps
`default_nettype none
module itfm_switch_model
(
    // contact state
    input  wire logic [7:0] pressed,
    input  wire logic [7:0] nc_wired,
    // terminal lines
    output logic [7:0]      term
);
    // normally closed contact reads high until pressed
    assign term = pressed ^ nc_wired;
endmodule
`default_nettype wire

// [itfm_term_map.sv]
// one terminal: polarity correction and function decode
`timescale 1ns/1ps
`default_nettype none
module itfm_term_map
    import itfm_pkg::*;
(
    // terminal
    input  wire logic        raw,
    input  wire logic        pol,
    input  wire logic [5:0]  fsel,
    // decode
    output logic             level,
    output logic [63:0]      map,
    output logic [63:0]      hit
);

    always_comb
    begin
        level = raw ^ pol;
        map   = itfm_code_onehot(fsel);
        hit   = level ? map : 64'h0;
    end

endmodule
`default_nettype wire
